// >>> include/mrs_pkg.sv
`default_nettype none
// =====================================================================
// Shared constants of the manual reset and sequential read block
package mrs_pkg;
  // =====================================================================
  // Memory geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 11;
  localparam int MEM_DEPTH = 2048;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 11'h7ff;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 11'h001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

  // =====================================================================
  // Slave address byte layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int DEV_TYPE_HI = 7;
  localparam int DEV_TYPE_LO = 4;
  localparam int PAGE_HI = 3;
  localparam int PAGE_LO = 1;
  localparam int RW_BIT = 0;
  localparam int PAGE_W = PAGE_HI - PAGE_LO + 1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // =====================================================================
  // Pin positions in the synchroniser vector
  localparam int PIN_SCL = 3;
  localparam int PIN_SDA = 2;
  localparam int PIN_RHI = 1;
  localparam int PIN_RLO = 0;
  localparam int PIN_W = 4;

  // =====================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEBASE_NS = 1000000;
  localparam int TIMEBASE_MS = 1;
  localparam int RESET_TIMEOUT_PERIOD_MS = 200;
  localparam int TICK_CYCLES_DEF = TIMEBASE_NS / CLK_PERIOD_NS;
  localparam int RST_TICKS_DEF = RESET_TIMEOUT_PERIOD_MS / TIMEBASE_MS;
  localparam int TICK_W = 16;
  localparam int PCNT_W = 8;

  // =====================================================================
  // Serial engine states
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_DEVA  = 8'h02,
    ST_AACK  = 8'h04,
    ST_WADR  = 8'h08,
    ST_WACK  = 8'h10,
    ST_SEND  = 8'h20,
    ST_MACK  = 8'h40,
    ST_WSTOP = 8'h80
  } mrs_state_t;
endpackage
`default_nettype wire

// >>> include/mrs_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Carrier between the serial engine and the array
interface mrs_mem_if;
  logic rdEn;
  logic [mrs_pkg::ADDR_W-1:0] rdAddr;
  logic [mrs_pkg::DATA_W-1:0] rdData;
  logic wrEn;
  logic [mrs_pkg::ADDR_W-1:0] wrAddr;
  logic [mrs_pkg::DATA_W-1:0] wrData;
  modport ctrl (output rdEn, rdAddr, wrEn, wrAddr, wrData, input rdData);
  modport mem (input rdEn, rdAddr, wrEn, wrAddr, wrData, output rdData);
endinterface
`default_nettype wire

// >>> hdl/mrs_mem.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Byte array with registered read data
module mrs_mem
  import mrs_pkg::*;
(
  input wire logic core_clk, // Core clock
  mrs_mem_if.mem port        // Access from the engine
);
  logic [DATA_W-1:0] arrayQ [MEM_DEPTH];
  logic [DATA_W-1:0] rdDataQ;

  // Read and load share one clock; no reset on the array itself
  always_ff @(posedge core_clk) begin
    if (port.wrEn) begin
      arrayQ[port.wrAddr] <= port.wrData;
    end
    if (port.rdEn) begin
      rdDataQ <= arrayQ[port.rdAddr];
    end
  end

  assign port.rdData = rdDataQ;
endmodule
`default_nettype wire

// >>> hdl/mrs_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - Master opens a sequential read by current-address or random read, then continues.
// R02 - Each master acknowledge after a byte makes the device send another byte.
// R03 - Bytes come from consecutive addresses; counter spans every address bit.
// R04 - Past address 2047 the counter wraps to zero and sending goes on.
// R05 - Either reset pin acts as manual reset, sensing only its active edge.
// R06 - Rising edge on high reset pin, falling edge on low reset pin.
// R07 - A detected edge starts a 200 ms count driving the complementary reset.
// R08 - Complementary reset releases when the count expires, however long input stays.
// R09 - Memory is disabled while any reset condition is present.
// R10 - Input held past the timeout keeps the memory from acknowledging until release.
// R11 - Missing master acknowledge stops transmission; device waits for STOP.
// R12 - Address counter holds last accessed address plus one; current reads start there.
// R13 - Master ends a read by withholding acknowledge then issuing STOP.
// R14 - Reset interval is counted on a free-running timebase, length a parameter.
module mrs_top
  import mrs_pkg::*;
#(
  parameter logic [TICK_W-1:0] TICK_CYCLES = TICK_W'(TICK_CYCLES_DEF), // Core cycles per tick
  parameter logic [PCNT_W-1:0] RST_TICKS = PCNT_W'(RST_TICKS_DEF)      // Ticks per reset pulse
) (
  input wire logic core_clk,                 // 40 MHz core clock
  input wire logic sys_rst,                  // Async reset, active high
  input wire logic sclIn,                    // Bus clock from master
  input wire logic sdaIn,                    // Bus data level
  output logic sdaOut,                       // Bus data drive value
  output logic sdaOe,                        // Bus data enable, pulls low
  input wire logic rstHiIn,                  // High reset pin level
  output logic rstHiOut,                     // High reset pin drive value
  output logic rstHiOe,                      // High reset pin enable
  input wire logic rstLoInN,                 // Low reset pin level
  output logic rstLoOutN,                    // Low reset pin drive value
  output logic rstLoOeN,                     // Low reset pin enable, high drives
  input wire logic memLoadEn,                // Array preload strobe
  input wire logic [ADDR_W-1:0] memLoadAddr, // Array preload address
  input wire logic [DATA_W-1:0] memLoadData  // Array preload data
);
  mrs_mem_if memIf ();
  mrs_state_t stateQ;
  logic [PIN_W-1:0] s1Q, s2Q, s3Q;
  logic [3:0] cntQ;
  logic [DATA_W-1:0] shiftQ, txQ;
  logic [PAGE_W-1:0] pageQ;
  logic [ADDR_W-1:0] addrQ;
  logic rwQ, sdaOeQ, sdaOutQ;
  logic [TICK_W-1:0] tickCntQ;
  logic tickQ, pulseQ, srcHiQ;
  logic [PCNT_W-1:0] pulseCntQ;
  logic rstHiOeQ, rstHiOutQ, rstLoOeQ, rstLoOutQ;
  logic sclRise, sclFall, sdaS, startSeen, stopSeen, memBlocked, fsmFree;
  logic hiRise, loFall, addrLoad;

  function automatic logic edgeUp(input logic now, input logic was);
    return now & ~was;
  endfunction

  // =====================================================================
  // Pin synchronisers; only the second stage reads the first
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1Q <= '1;
      s2Q <= '1;
      s3Q <= '1;
    end else begin
      s1Q <= {sclIn, sdaIn, rstHiIn, rstLoInN};
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  // Bus events seen on the core clock
  assign sdaS = s2Q[PIN_SDA];
  assign sclRise = edgeUp(s2Q[PIN_SCL], s3Q[PIN_SCL]);
  assign sclFall = edgeUp(s3Q[PIN_SCL], s2Q[PIN_SCL]);
  assign startSeen = s2Q[PIN_SCL] && s3Q[PIN_SCL] && edgeUp(s3Q[PIN_SDA], sdaS);
  assign stopSeen = s2Q[PIN_SCL] && s3Q[PIN_SCL] && edgeUp(sdaS, s3Q[PIN_SDA]);

  // Pin edges; edges on a pin we drive are our own and are masked
  assign hiRise = edgeUp(s2Q[PIN_RHI], s3Q[PIN_RHI]) && !rstHiOeQ; // R06
  assign loFall = edgeUp(s3Q[PIN_RLO], s2Q[PIN_RLO]) && !rstLoOeQ; // R06
  // Level on either pin blocks too, so a held input keeps blocking after the pulse
  assign memBlocked = pulseQ || s2Q[PIN_RHI] || !s2Q[PIN_RLO]; // R09 R10

  // =====================================================================
  // Free-running timebase
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCntQ <= '0;
      tickQ <= 1'b0;
    end else if (tickCntQ == TICK_CYCLES - TICK_W'(1)) begin
      tickCntQ <= '0;
      tickQ <= 1'b1; // R14
    end else begin
      tickCntQ <= tickCntQ + TICK_W'(1);
      tickQ <= 1'b0;
    end
  end

  // Manual reset pulse; one extra tick covers the unaligned first tick
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseQ <= 1'b0;
      srcHiQ <= 1'b0;
      pulseCntQ <= '0;
    end else if (!pulseQ) begin
      if (hiRise || loFall) begin
        pulseQ <= 1'b1; // R05 R07
        srcHiQ <= hiRise;
        pulseCntQ <= '0;
      end
    end else if (tickQ) begin
      if (pulseCntQ == RST_TICKS) begin
        pulseQ <= 1'b0; // R08
      end else begin
        pulseCntQ <= pulseCntQ + PCNT_W'(1); // R14
      end
    end
  end

  // Complementary reset drive, registered straight onto the pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstLoOeQ <= 1'b0;
      rstLoOutQ <= 1'b1;
      rstHiOeQ <= 1'b0;
      rstHiOutQ <= 1'b0;
    end else begin
      rstLoOeQ <= pulseQ && srcHiQ; // R07
      rstLoOutQ <= !(pulseQ && srcHiQ);
      rstHiOeQ <= pulseQ && !srcHiQ; // R07
      rstHiOutQ <= pulseQ && !srcHiQ;
    end
  end

  // =====================================================================
  // Serial engine; blocking has priority so no ACK slips out in reset
  assign fsmFree = !(memBlocked && stateQ != ST_IDLE) && !stopSeen && !startSeen;
  assign memIf.rdEn = fsmFree && sclRise &&
    ((stateQ == ST_AACK && rwQ) || (stateQ == ST_MACK && !sdaS)); // R02
  assign memIf.rdAddr = addrQ; // R12
  assign memIf.wrEn = memLoadEn;
  assign memIf.wrAddr = memLoadAddr;
  assign memIf.wrData = memLoadData;
  assign addrLoad = fsmFree && stateQ == ST_WADR && sclFall && cntQ == BIT_LAST;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= ST_IDLE;
      cntQ <= '0;
      shiftQ <= '0;
      txQ <= '0;
      rwQ <= 1'b0;
      pageQ <= '0;
      sdaOeQ <= 1'b0;
    end else if (memBlocked && stateQ != ST_IDLE) begin
      stateQ <= ST_WSTOP; // R09 R10
      sdaOeQ <= 1'b0;
    end else if (stopSeen) begin
      stateQ <= ST_IDLE;
      sdaOeQ <= 1'b0;
    end else if (startSeen) begin
      stateQ <= ST_DEVA;
      cntQ <= '0;
      sdaOeQ <= 1'b0;
    end else begin
      unique case (stateQ)
        ST_IDLE, ST_WSTOP: begin
        end
        ST_DEVA, ST_WADR: begin
          if (sclRise) begin
            shiftQ <= {shiftQ[DATA_W-2:0], sdaS};
            cntQ <= cntQ + BIT_STEP;
          end else if (sclFall && cntQ == BIT_LAST) begin
            cntQ <= '0;
            if (stateQ == ST_WADR) begin
              stateQ <= ST_WACK;
              sdaOeQ <= 1'b1;
            end else if (shiftQ[DEV_TYPE_HI:DEV_TYPE_LO] == DEV_TYPE) begin
              stateQ <= ST_AACK;
              sdaOeQ <= 1'b1;
              rwQ <= shiftQ[RW_BIT]; // R01
              pageQ <= shiftQ[PAGE_HI:PAGE_LO];
            end else begin
              stateQ <= ST_WSTOP;
            end
          end
        end
        ST_AACK: begin
          if (sclFall) begin
            if (rwQ) begin
              stateQ <= ST_SEND;
              sdaOeQ <= ~memIf.rdData[DATA_W-1];
              txQ <= {memIf.rdData[DATA_W-2:0], 1'b0};
            end else begin
              stateQ <= ST_WADR;
              sdaOeQ <= 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (sclRise) begin
            cntQ <= cntQ + BIT_STEP;
          end else if (sclFall) begin
            if (cntQ == BIT_LAST) begin
              stateQ <= ST_MACK; // R02
              cntQ <= '0;
              sdaOeQ <= 1'b0;
            end else begin
              sdaOeQ <= ~txQ[DATA_W-1];
              txQ <= {txQ[DATA_W-2:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            stateQ <= sdaS ? ST_WSTOP : ST_AACK; // R11 R02
          end
        end
        ST_WACK: begin
          // Data bytes of a write are not taken; only the pointer is
          if (sclFall) begin
            stateQ <= ST_WSTOP;
            sdaOeQ <= 1'b0;
          end
        end
      endcase
    end
  end

  // Address counter: loaded by a dummy write, stepped on every byte read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrQ <= ADDR_RST;
    end else if (addrLoad) begin
      addrQ <= {pageQ, shiftQ}; // R12
    end else if (memIf.rdEn) begin
      addrQ <= addrQ + ADDR_STEP; // R03 R04 R12
    end
  end

  // Open drain: the value is low once out of reset (high in reset), the enable does the work
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOutQ <= 1'b1;
    end else begin
      sdaOutQ <= 1'b0;
    end
  end

  mrs_mem u_mem (
    .core_clk(core_clk),
    .port(memIf.mem)
  );

  assign sdaOut = sdaOutQ;
  assign sdaOe = sdaOeQ;
  assign rstHiOut = rstHiOutQ;
  assign rstHiOe = rstHiOeQ;
  assign rstLoOutN = rstLoOutQ;
  assign rstLoOeN = rstLoOeQ;

  // =====================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_ackMore;
    (fsmFree && stateQ == ST_MACK && sclRise && !sdaS) |-> memIf.rdEn ##1 stateQ == ST_AACK;
  endproperty
  a_ackMore: assert property (p_ackMore) else $error("ack did not fetch next byte"); // R02

  property p_addrStep;
    (memIf.rdEn && !addrLoad) |=> addrQ == $past(addrQ) + ADDR_STEP;
  endproperty
  a_addrStep: assert property (p_addrStep) else $error("read counter did not step"); // R03

  property p_wrap;
    (memIf.rdEn && addrQ == ADDR_MAX) |=> addrQ == ADDR_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero"); // R04

  property p_hiEdge;
    (hiRise && !pulseQ) |=> pulseQ && srcHiQ ##1 rstLoOeQ && !rstLoOutQ;
  endproperty
  a_hiEdge: assert property (p_hiEdge) else $error("high pin edge gave no pulse"); // R06

  property p_loEdge;
    (loFall && !pulseQ && !hiRise) |=> pulseQ && !srcHiQ ##1 rstHiOeQ && rstHiOutQ;
  endproperty
  a_loEdge: assert property (p_loEdge) else $error("low pin edge gave no pulse"); // R06

  property p_levelNoPulse;
    (!pulseQ && !hiRise && !loFall) |=> !pulseQ;
  endproperty
  a_levelNoPulse: assert property (p_levelNoPulse) else $error("pulse without edge"); // R05

  property p_pulseEnd;
    (pulseQ && tickQ && pulseCntQ == RST_TICKS) |=> !pulseQ ##1 !rstLoOeQ && !rstHiOeQ;
  endproperty
  a_pulseEnd: assert property (p_pulseEnd) else $error("pulse outlived its count"); // R08

  property p_pulseHold;
    (pulseQ && !tickQ) |=> pulseQ && $stable(pulseCntQ);
  endproperty
  a_pulseHold: assert property (p_pulseHold) else $error("pulse count moved off tick"); // R07

  property p_blockRelease;
    (memBlocked && stateQ != ST_IDLE) |=> !sdaOeQ && stateQ == ST_WSTOP;
  endproperty
  a_blockRelease: assert property (p_blockRelease) else $error("bus driven while blocked"); // R09

  property p_noAckHeld;
    (!s2Q[PIN_RLO] || s2Q[PIN_RHI]) |=> !(stateQ == ST_AACK && $rose(sdaOeQ));
  endproperty
  a_noAckHeld: assert property (p_noAckHeld) else $error("ack given with reset held"); // R10

  property p_nackStop;
    (fsmFree && stateQ == ST_MACK && sclRise && sdaS) |=> stateQ == ST_WSTOP && !sdaOeQ;
  endproperty
  a_nackStop: assert property (p_nackStop) else $error("no stop after master nack"); // R11

  c_seqRead: cover property (stateQ == ST_MACK && sclRise && !sdaS ##[1:400] stateQ == ST_SEND);
  c_wrap: cover property (memIf.rdEn && addrQ == ADDR_MAX);
  c_pulseHi: cover property (pulseQ && srcHiQ ##1 !pulseQ);
  c_pulseLo: cover property (pulseQ && !srcHiQ ##1 !pulseQ);
endmodule
`default_nettype wire

// >>> sim/mrs_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Bus master model; SCL stands high between frames, 8 core cycles a bit
module mrs_i2c_master (
  input wire logic core_clk, // Core clock
  input wire logic sdaLine,  // Resolved SDA level
  output logic sclOut,       // SCL drive, idle high
  output logic sdaDrv        // SDA drive, 1 releases the line
);
  // Idle bus at time zero
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One bit; data moves a cycle after SCL falls so it never reads as START
  task automatic bit_x(input logic b, output logic r);
    tk(1);
    sdaDrv <= b;
    tk(3);
    sclOut <= 1'b1;
    tk(3);
    r = sdaLine;
    tk(1);
    sclOut <= 1'b0;
  endtask

  // START, also usable as repeated START from inside a frame
  task automatic start_c;
    tk(1);
    sdaDrv <= 1'b1;
    tk(3);
    sclOut <= 1'b1;
    tk(3);
    sdaDrv <= 1'b0;
    tk(3);
    sclOut <= 1'b0;
  endtask

  // STOP leaves both lines high
  task automatic stop_c;
    tk(1);
    sdaDrv <= 1'b0;
    tk(3);
    sclOut <= 1'b1;
    tk(3);
    sdaDrv <= 1'b1;
    tk(4);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // Low on the ninth bit asks for more; high ends the read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
endmodule
`default_nettype wire

// >>> sim/manual_reset_and_seq_read_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Bench with a byte model of the array and address counter
module manual_reset_and_seq_read_tb_top;
  import mrs_pkg::*;
  localparam int TC = 16;
  localparam int RT = 4;
  logic core_clk, sys_rst, sclW, sdaDrv, sdaOut, sdaOe;
  logic rstHiTb, rstHiOut, rstHiOe, rstLoTbN, rstLoOutN, rstLoOeN, memLoadEn;
  logic [ADDR_W-1:0] memLoadAddr;
  logic [DATA_W-1:0] memLoadData;
  wire logic sdaW, rstHiW, rstLoWN, drvLo, drvHi;
  int error_cnt, n_checks, ptr;
  int mem[MEM_DEPTH];

  // =====================================================================
  // Wires with pull-up on SDA and low pin, pull-down on high pin
  assign sdaW = sdaDrv & ~sdaOe;
  assign rstHiW = rstHiTb | (rstHiOe & rstHiOut);
  assign rstLoWN = rstLoTbN & ~(rstLoOeN & ~rstLoOutN);
  assign drvLo = rstLoOeN & ~rstLoOutN;
  assign drvHi = rstHiOe & rstHiOut;

  mrs_top #(.TICK_CYCLES(TICK_W'(TC)), .RST_TICKS(PCNT_W'(RT))) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclIn(sclW), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .rstHiIn(rstHiW), .rstHiOut(rstHiOut),
    .rstHiOe(rstHiOe), .rstLoInN(rstLoWN), .rstLoOutN(rstLoOutN),
    .rstLoOeN(rstLoOeN), .memLoadEn(memLoadEn), .memLoadAddr(memLoadAddr),
    .memLoadData(memLoadData));

  mrs_i2c_master mst (.core_clk(core_clk), .sdaLine(sdaW), .sclOut(sclW), .sdaDrv(sdaDrv));

  // Core clock, 25 ns
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // Bus sequences; page bits of the read address byte are random, zero in blocked_try
  task automatic cur_read(input int n);
    logic k;
    logic [7:0] d;
    mst.start_c();
    mst.wr_byte({DEV_TYPE, 3'($urandom), 1'b1}, k);
    chk("readAck", 1, 32'(k));
    chk("sdaOut", 0, 32'(sdaOut));
    for (int i = 0; i < n; i++) begin
      mst.rd_byte(i < n - 1, d);
      chk("readData", 32'(mem[ptr]), 32'(d));
      ptr = (ptr + 1) % MEM_DEPTH;
    end
    mst.stop_c();
  endtask

  task automatic rnd_read(input logic [ADDR_W-1:0] a, input int n);
    logic k;
    mst.start_c();
    mst.wr_byte({DEV_TYPE, a[10:8], 1'b0}, k);
    chk("devAck", 1, 32'(k));
    mst.wr_byte(a[7:0], k);
    chk("wordAck", 1, 32'(k));
    ptr = int'(a);
    cur_read(n);
  endtask

  task automatic blocked_try;
    logic k;
    mst.start_c();
    mst.wr_byte({DEV_TYPE, 3'h0, 1'b1}, k);
    chk("blockedAck", 0, 32'(k));
    mst.stop_c();
  endtask

  // Drive on the far pin must last the whole count and then let go
  task automatic pulse(input logic viaHi);
    int w, len;
    w = 0;
    len = 0;
    while (!(viaHi ? drvLo : drvHi) && w < 20) begin
      tk(1);
      w++;
    end
    chk("pulseStart", 1, 32'(w < 20));
    while ((viaHi ? drvLo : drvHi) && len < 200) begin
      tk(1);
      len++;
    end
    chk("pulseLen", 1, 32'(len >= RT * TC && len <= (RT + 1) * TC));
    // Once released, the far pins go back to their idle drive values
    chk("loOutIdle", 1, 32'(rstLoOutN));
    chk("hiOutIdle", 0, 32'(rstHiOut));
  endtask

  // Hang guard, several times the expected run
  initial begin
    tk(30000);
    error_cnt++;
    conclude();
  end

  // =====================================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    rstHiTb = 1'b0;
    rstLoTbN = 1'b1;
    memLoadEn = 1'b0;
    memLoadAddr = '0;
    memLoadData = '0;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(32'hb966af52));
    tk(3);
    sys_rst <= 1'b0;
    for (int a = 0; a < MEM_DEPTH; a++) begin
      mem[a] = int'($urandom % 256);
      memLoadEn <= 1'b1;
      memLoadAddr <= ADDR_W'(a);
      memLoadData <= DATA_W'(mem[a]);
      tk(1);
    end
    memLoadEn <= 1'b0;
    tk(4);
    rnd_read(11'h7fd, 6);
    cur_read(2);
    for (int i = 0; i < 3; i++) rnd_read(ADDR_W'($urandom), 1 + int'($urandom % 4));
    // Short press on the high pin: memory shut out while the count runs
    rstHiTb <= 1'b1;
    tk(3);
    fork
      pulse(1'b1);
      begin
        tk(2);
        rstHiTb <= 1'b0;
        blocked_try();
      end
    join
    tk(4);
    // Low pin held past the count: one pulse only, memory shut until release
    rstLoTbN <= 1'b0;
    pulse(1'b0);
    blocked_try();
    chk("noRetrigger", 0, 32'(drvHi));
    rstLoTbN <= 1'b1;
    tk(8);
    cur_read(2);
    // High pin held past the count
    rstHiTb <= 1'b1;
    pulse(1'b1);
    blocked_try();
    rstHiTb <= 1'b0;
    tk(8);
    cur_read(3);
    conclude();
  end
endmodule
`default_nettype wire
